// [exec_trap_pkg.sv]
// Constants, field layouts and carrier types of the trap, timer and parity block
package exec_trap_pkg;
  // Timebase derived from the 40 MHz bus clock
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          TIMEBASE_HZ   = 1_000_000;
  localparam int          TICK_CYCLES   = CLK_HZ / TIMEBASE_HZ;
  localparam logic [5:0]  TICK_LAST     = 6'(TICK_CYCLES - 1);
  // Interval timer: 12 bits, one overflow per 4 ms at 1 us ticks
  localparam int          INTERVAL_MS   = 4;
  localparam int          INTERVAL_TICKS = INTERVAL_MS * 1000;
  localparam logic [11:0] INTERVAL_TOP  = 12'hfff;
  localparam logic [11:0] INTERVAL_PRESET = 12'(4096 - INTERVAL_TICKS);
  // Microsecond timer: 10 bits, natural wrap every 1.024 ms
  localparam logic [9:0]  USEC_TOP      = 10'h3ff;
  // Register byte offsets
  localparam logic [7:0]  OFF_MODE      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_PCODE     = 8'h08;
  localparam logic [7:0]  OFF_TIMERS    = 8'h0c;
  // Mode control word layout
  localparam int          MODE_NF_LSB   = 8;
  localparam int          MODE_REPORT   = 16;
  localparam logic [16:0] MODE_RESET    = 17'h00000;
  localparam logic [16:0] MODE_WMASK    = 17'h1f7ff;
  // Fetch-class trap indices
  localparam logic [2:0]  F_INTERVAL    = 3'h5;
  localparam logic [2:0]  F_USEC        = 3'h6;
  // Non-fetch-class trap indices
  localparam logic [2:0]  NF_DMT        = 3'h3;
  localparam logic [2:0]  NF_MACHINE_CHECK_SUMMARY       = 3'h4;
  // Parity error codes
  localparam logic [2:0]  PCODE_NONE    = 3'h0;
  localparam logic [2:0]  PCODE_HB_LEFT = 3'h1;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Fetch-class requests raised by other units
  typedef struct packed {
    logic decode_net_parity_error;
    logic external_io_interrupt;
    logic instruction_end_trap;
    logic soft_cache_parity_error;
    logic diagnostic_processor_request;
    logic correctable_memory_error;
  } fetch_src_t;

  // Non-fetch-class requests raised by other units
  typedef struct packed {
    logic restricted_instruction_trap;
    logic branch_cache_fault;
    logic address_trap_on_write;
    logic direct_memory_transfer_request;
    logic missing_memory_module;
    logic control_store_parity_error;
    logic uncorrectable_memory_error;
  } nonfetch_src_t;

  // ALU operands with their byte parity bits
  typedef struct packed {
    logic [15:0] high_b_bus_half;
    logic [1:0]  high_b_par;
    logic [15:0] low_b_bus_half;
    logic [1:0]  low_b_par;
    logic [15:0] high_a_bus_half;
    logic [1:0]  high_a_par;
    logic [15:0] low_a_bus_half;
    logic [1:0]  low_a_par;
    logic [7:0]  extended_a_bus;
    logic        extended_a_par;
  } operand_t;

  // Complete state of the block
  typedef struct packed {
    logic [5:0]  div;
    logic [11:0] interval;
    logic [9:0]  usec;
    logic        int_pend;
    logic        usec_pend;
    logic        traps_on;
    logic        machine_check_summary_sum;
    logic        display;
    logic [2:0]  pcode;
    logic        trap_request;
    logic [3:0]  trap_code;
    logic [16:0] mode;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;
endpackage

// [exec_unit_trap_timer_parity.sv]
// Trap gating, system timers and ALU operand parity checking with AXI4-Lite registers
`timescale 1ns/1ps
module exec_unit_trap_timer_parity (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write channels
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [7:0]                    awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic [1:0]                         bresp,
  // AXI4-Lite read channels
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [7:0]                    araddr,
  input  wire logic [2:0]                    arprot,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  // Microcode controls
  input  wire logic                          return_to_fetch,
  input  wire logic                          global_trap_enable_op,
  input  wire logic                          global_trap_disable_op,
  input  wire logic                          transfer_trap_suppress_field,
  input  wire logic                          parity_check_disable,
  input  wire logic                          parity_code_service,
  input  wire logic                          trap_accept,
  // Trap sources from other units
  input  wire exec_trap_pkg::fetch_src_t     fetch_src,
  input  wire exec_trap_pkg::nonfetch_src_t  nonfetch_src,
  input  wire logic [7:0]                    unit_parity_errors,
  input  wire logic                          stage_seven_clock,
  // ALU operands
  input  wire exec_trap_pkg::operand_t       operands,
  // To microsequencer, pipeline control unit and display
  output logic                               trap_request,
  output logic [3:0]                         trap_code,
  output logic [2:0]                         parity_error_code,
  output logic                               machine_check_summary,
  output logic                               diagnostic_display
);

  exec_trap_pkg::state_t s;
  exec_trap_pkg::state_t next_s;

  logic       tick;
  logic [7:0] fvec;
  logic [7:0] nfvec;
  logic [7:0] f_live;
  logic [7:0] nf_live;
  logic [7:0] perr;
  logic [7:0] perr_checked;
  logic [3:0] b_err;
  logic [2:0] a_err;
  logic       machine_check_summary_live;
  logic       wr_fire;
  logic       svc;

  // Index of the lowest set bit
  function automatic logic [2:0] lowest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Odd parity checks per byte
  assign b_err[0] = ~^{operands.high_b_bus_half[15:8], operands.high_b_par[1]};
  assign b_err[1] = ~^{operands.high_b_bus_half[7:0], operands.high_b_par[0]};
  assign b_err[2] = ~^{operands.low_b_bus_half[15:8], operands.low_b_par[1]};
  assign b_err[3] = ~^{operands.low_b_bus_half[7:0], operands.low_b_par[0]};
  assign a_err[0] = (~^operands.high_a_bus_half[15:8] != operands.high_a_par[1])
                  | (~^operands.high_a_bus_half[7:0] != operands.high_a_par[0]);
  assign a_err[1] = (~^operands.low_a_bus_half[15:8] != operands.low_a_par[1])
                  | (~^operands.low_a_bus_half[7:0] != operands.low_a_par[0]);
  assign a_err[2] = (~^operands.extended_a_bus != operands.extended_a_par);

  // Error vector indexed by code, bit 0 meaning no error
  assign perr         = {a_err[2], a_err[1], a_err[0], b_err[3], b_err[2],
                         b_err[1], b_err[0], 1'b0};
  assign perr_checked = parity_check_disable ? 8'h00 : perr;

  // Trap source vectors and their gating
  assign machine_check_summary_live = s.mode[exec_trap_pkg::MODE_REPORT]
                   & (s.machine_check_summary_sum | (|perr_checked));
  assign fvec  = {fetch_src.decode_net_parity_error, s.usec_pend, s.int_pend,
                  fetch_src.external_io_interrupt, fetch_src.instruction_end_trap,
                  fetch_src.soft_cache_parity_error,
                  fetch_src.diagnostic_processor_request,
                  fetch_src.correctable_memory_error};
  assign nfvec = {nonfetch_src.restricted_instruction_trap,
                  nonfetch_src.branch_cache_fault,
                  nonfetch_src.address_trap_on_write, machine_check_summary_live,
                  nonfetch_src.direct_memory_transfer_request,
                  nonfetch_src.missing_memory_module,
                  nonfetch_src.control_store_parity_error,
                  nonfetch_src.uncorrectable_memory_error};
  assign f_live  = fvec & s.mode[7:0] & {8{return_to_fetch}};
  assign nf_live = nfvec & {s.mode[15:12], ~transfer_trap_suppress_field,
                            s.mode[10:8]};

  // Timebase tick and bus handshake terms
  assign tick    = (s.div == exec_trap_pkg::TICK_LAST);
  assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;
  assign svc     = parity_code_service
                 | (wr_fire & (s.awaddr == exec_trap_pkg::OFF_PCODE)
                    & s.wstrb[0] & s.wdata[0]);
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready  = ~s.w_got & ~s.bvalid;
  assign arready = ~s.rvalid;

  // Next-state logic
  always_comb
  begin
    next_s = s;
    // 1 MHz timebase
    next_s.div = tick ? 6'h00 : s.div + 6'h01;
    // Interval timer with preset on overflow
    if (tick)
    begin
      if (s.interval == exec_trap_pkg::INTERVAL_TOP)
      begin
        next_s.interval = exec_trap_pkg::INTERVAL_PRESET;
      end
      else
      begin
        next_s.interval = s.interval + 12'h001;
      end
      next_s.usec = s.usec + 10'h001;
    end
    // Pending timer traps, cleared when taken, set wins
    if (trap_accept && s.trap_request && s.trap_code == {1'b0, exec_trap_pkg::F_INTERVAL})
    begin
      next_s.int_pend = 1'b0;
    end
    if (trap_accept && s.trap_request && s.trap_code == {1'b0, exec_trap_pkg::F_USEC})
    begin
      next_s.usec_pend = 1'b0;
    end
    if (tick && s.interval == exec_trap_pkg::INTERVAL_TOP)
    begin
      next_s.int_pend = 1'b1;
    end
    if (tick && s.usec == exec_trap_pkg::USEC_TOP)
    begin
      next_s.usec_pend = 1'b1;
    end
    // Global trap enable, disable wins
    if (global_trap_disable_op)
    begin
      next_s.traps_on = 1'b0;
    end
    else if (global_trap_enable_op)
    begin
      next_s.traps_on = 1'b1;
    end
    // Trap selection, non-fetch class first
    if (s.traps_on && (|nf_live))
    begin
      next_s.trap_request = 1'b1;
      next_s.trap_code    = {1'b1, lowest(nf_live)};
    end
    else if (s.traps_on && (|f_live))
    begin
      next_s.trap_request = 1'b1;
      next_s.trap_code    = {1'b0, lowest(f_live)};
    end
    else
    begin
      next_s.trap_request = 1'b0;
      next_s.trap_code    = 4'h0;
    end
    // Machine check summary and display
    if (stage_seven_clock)
    begin
      next_s.machine_check_summary_sum = |unit_parity_errors;
      next_s.display  = s.machine_check_summary_sum;
    end
    // First parity error capture, a new error beats the service
    if ((s.pcode == exec_trap_pkg::PCODE_NONE || svc) && (|perr_checked))
    begin
      next_s.pcode = lowest(perr_checked);
    end
    else if (svc)
    begin
      next_s.pcode = exec_trap_pkg::PCODE_NONE;
    end
    // Write address and data capture
    if (awvalid && awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    // Register write and response
    if (wr_fire)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = exec_trap_pkg::RESP_OKAY;
      case (s.awaddr)
        exec_trap_pkg::OFF_MODE:
        begin
          if (s.wstrb[0])
          begin
            next_s.mode[7:0] = s.wdata[7:0];
          end
          if (s.wstrb[1])
          begin
            next_s.mode[15:8] = s.wdata[15:8] & exec_trap_pkg::MODE_WMASK[15:8];
          end
          if (s.wstrb[2])
          begin
            next_s.mode[16] = s.wdata[16];
          end
        end
        exec_trap_pkg::OFF_STATUS, exec_trap_pkg::OFF_PCODE,
        exec_trap_pkg::OFF_TIMERS:
        begin
          next_s.bresp = exec_trap_pkg::RESP_OKAY;
        end
        default:
        begin
          next_s.bresp = exec_trap_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end
    // Register read
    if (arvalid && arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = exec_trap_pkg::RESP_OKAY;
      case (araddr)
        exec_trap_pkg::OFF_MODE:
        begin
          next_s.rdata = {15'h0000, s.mode};
        end
        exec_trap_pkg::OFF_STATUS:
        begin
          next_s.rdata = {8'h00, s.display, s.machine_check_summary_sum, s.traps_on,
                          s.trap_request, s.trap_code, nfvec, fvec};
        end
        exec_trap_pkg::OFF_PCODE:
        begin
          next_s.rdata = {29'h00000000, s.pcode};
        end
        exec_trap_pkg::OFF_TIMERS:
        begin
          next_s.rdata = {6'h00, s.usec, 4'h0, s.interval};
        end
        default:
        begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = exec_trap_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s          <= '0;
      s.interval <= exec_trap_pkg::INTERVAL_PRESET;
      s.mode     <= exec_trap_pkg::MODE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs from flip-flops
  assign bvalid                = s.bvalid;
  assign bresp                 = s.bresp;
  assign rvalid                = s.rvalid;
  assign rdata                 = s.rdata;
  assign rresp                 = s.rresp;
  assign trap_request          = s.trap_request;
  assign trap_code             = s.trap_code;
  assign parity_error_code     = s.pcode;
  assign machine_check_summary = s.machine_check_summary_sum;
  assign diagnostic_display    = s.display;

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence overflow_interval;
    tick && s.interval == exec_trap_pkg::INTERVAL_TOP;
  endsequence
  sequence reloaded_interval;
    s.interval == exec_trap_pkg::INTERVAL_PRESET && s.int_pend;
  endsequence

  a_interval_wrap: assert property (overflow_interval |=> reloaded_interval)
    else $error("interval timer did not reload on overflow");
  a_usec_wrap: assert property (tick && s.usec == exec_trap_pkg::USEC_TOP
                                |=> s.usec == 10'h000 && s.usec_pend)
    else $error("microsecond timer did not wrap");
  a_fetch_boundary: assert property (s.trap_request && !s.trap_code[3]
                                     |-> $past(return_to_fetch))
    else $error("fetch trap outside return to fetch");
  a_nonfetch_any: assert property (s.traps_on && (|nf_live)
                                   |=> s.trap_request && s.trap_code[3])
    else $error("non-fetch trap not raised");
  a_global_off: assert property (global_trap_disable_op
                                 |=> !s.traps_on ##1 !s.trap_request)
    else $error("trap raised after global disable");
  a_transfer_block: assert property (transfer_trap_suppress_field
                                     |=> s.trap_code != {1'b1, exec_trap_pkg::NF_DMT})
    else $error("transfer trap not suppressed");
  a_mask_eoi: assert property (!s.mode[3] |=> s.trap_code != 4'h3)
    else $error("masked end of instruction trap taken");
  a_summary_stage: assert property (stage_seven_clock
                                    |=> s.machine_check_summary_sum == ($past(unit_parity_errors) != 8'h00))
    else $error("machine check summary wrong");
  a_display_beat: assert property (stage_seven_clock
                                   |=> s.display == $past(s.machine_check_summary_sum))
    else $error("display not one beat behind summary");
  a_report_gate: assert property (s.trap_request
                                  && s.trap_code == {1'b1, exec_trap_pkg::NF_MACHINE_CHECK_SUMMARY}
                                  |-> $past(s.mode[exec_trap_pkg::MODE_REPORT]))
    else $error("parity trap forwarded without report enable");
  a_code_hold: assert property (s.pcode != exec_trap_pkg::PCODE_NONE && !svc
                                |=> $stable(s.pcode))
    else $error("captured parity code overwritten");
  a_code_prio: assert property (s.pcode == exec_trap_pkg::PCODE_NONE && perr_checked[1]
                                |=> s.pcode == exec_trap_pkg::PCODE_HB_LEFT)
    else $error("parity code priority wrong");
  a_check_off: assert property (parity_check_disable && !svc
                                && s.pcode == exec_trap_pkg::PCODE_NONE
                                |=> s.pcode == exec_trap_pkg::PCODE_NONE)
    else $error("parity captured while check disabled");

endmodule

// [microseq_model.sv]
// Microsequencer model: marks instruction boundaries and takes each trap shown
`timescale 1ns/1ps
module microseq_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Boundary wish from the bench, trap from the block
  input  wire logic at_boundary,
  input  wire logic trap_request,
  // Back to the block
  output logic      return_to_fetch,
  output logic      trap_accept
);
  // Registered like microcode outputs; accept pulses on every other cycle while a trap is shown
  always_ff @(posedge aclk)
  begin
    return_to_fetch <= aresetn & at_boundary;
    trap_accept     <= aresetn & trap_request & !trap_accept;
  end
endmodule

// [exec_unit_trap_timer_parity_test.sv]
// Self-checking bench for the trap, timer and parity block
`timescale 1ns/1ps
module exec_unit_trap_timer_parity_test;
  // Parity case: operand bits to flip, check disable, expected code
  typedef struct packed {logic [80:0] flip; logic dis; logic [2:0] code;} row_t;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, at_boundary = 1'h0, stage_seven_clock = 1'h0;
  logic global_trap_enable_op = 1'h0, global_trap_disable_op = 1'h0;
  logic transfer_trap_suppress_field = 1'h0, parity_check_disable = 1'h0;
  logic parity_code_service = 1'h0, machine_check_summary, diagnostic_display;
  logic awready, wready, bvalid, arready, rvalid, trap_request, return_to_fetch, trap_accept;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, unit_parity_errors = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  trap_code;
  logic [1:0]  bresp, rresp, rr;
  logic [2:0]  parity_error_code;
  exec_trap_pkg::fetch_src_t    fetch_src = '0;
  exec_trap_pkg::nonfetch_src_t nonfetch_src = '0;
  exec_trap_pkg::operand_t      good, operands;
  row_t rows [9];
  int   err_count = 0, tests_run = 0, cyc = 0, rel = 0;

  exec_unit_trap_timer_parity exec_unit_trap_timer_parity_i (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .return_to_fetch, .global_trap_enable_op,
    .global_trap_disable_op, .transfer_trap_suppress_field, .parity_check_disable,
    .parity_code_service, .trap_accept, .fetch_src, .nonfetch_src, .unit_parity_errors,
    .stage_seven_clock, .operands, .trap_request, .trap_code, .parity_error_code,
    .machine_check_summary, .diagnostic_display);
  microseq_model microseq_model_i (
    .aclk, .aresetn, .at_boundary, .trap_request, .return_to_fetch, .trap_accept);

  // Clock, cycle count and hang limit
  always #12.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      conclude;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // AXI4-Lite write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    while (pa | pw)
    begin
      @(negedge aclk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
      pa = pa & !ta;
      pw = pw & !tw;
    end
    bready <= 1'h1;
    do
      @(negedge aclk);
    while (bvalid !== 1'h1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask

  // AXI4-Lite read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
      @(negedge aclk);
    while (arready !== 1'h1);
    @(posedge aclk);
    arvalid <= 1'h0;
    do
      @(negedge aclk);
    while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask

  // Let traps settle, compare request and code (code ignored when no request)
  task automatic tr(input logic [4:0] e, input string m);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(e[4] ? 32'({trap_request, trap_code}) : 32'(trap_request), 32'(e), m);
    @(posedge aclk);
  endtask

  // Service the parity code and see it clear
  task automatic svc;
    @(posedge aclk);
    parity_code_service <= 1'h1;
    @(posedge aclk);
    parity_code_service <= 1'h0;
    @(negedge aclk);
    chk(32'(parity_error_code), 32'h0, "code after service");
  endtask

  task automatic conclude;
    $display("err_count=%0d tests_run=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    good = '0;
    good.high_b_par = 2'h3;
    good.low_b_par = 2'h3;
    good.high_a_par = 2'h3;
    good.low_a_par = 2'h3;
    good.extended_a_par = 1'h1;
    operands = good;
    rows[0] = '{81'h1 << 64, 1'h0, 3'h1};
    rows[1] = '{81'h1 << 63, 1'h0, 3'h2};
    rows[2] = '{81'h1 << 46, 1'h0, 3'h3};
    rows[3] = '{81'h1 << 45, 1'h0, 3'h4};
    rows[4] = '{81'h1 << 29, 1'h0, 3'h5};
    rows[5] = '{81'h1 << 11, 1'h0, 3'h6};
    rows[6] = '{81'h1 << 1, 1'h0, 3'h7};
    rows[7] = '{81'h3 << 63, 1'h0, 3'h1};
    rows[8] = '{81'h1 << 64, 1'h1, 3'h0};
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk({24'h0, trap_request, parity_error_code, machine_check_summary, diagnostic_display,
      bvalid, rvalid}, 32'h0, "outputs in reset");
    @(posedge aclk);
    aresetn <= 1'h1;
    rel = cyc;
    axr(exec_trap_pkg::OFF_TIMERS, rd, rr);
    chk(32'(rd[11:0] - 12'h060), 32'(rd[25:16]), "interval preset");
    chk(rd, 32'(exec_trap_pkg::INTERVAL_PRESET), "timers after reset");
    foreach (rows[i])
    begin
      @(posedge aclk);
      operands <= good ^ rows[i].flip;
      parity_check_disable <= rows[i].dis;
      @(posedge aclk);
      operands <= good;
      parity_check_disable <= 1'h0;
      repeat (2) @(negedge aclk);
      chk(32'(parity_error_code), 32'(rows[i].code), "parity code");
      svc;
    end
    @(posedge aclk);
    operands <= good ^ (81'h1 << 46);
    @(posedge aclk);
    operands <= good ^ (81'h1 << 64);
    @(posedge aclk);
    operands <= good;
    repeat (2) @(negedge aclk);
    chk(32'(parity_error_code), 32'h3, "first code kept");
    axw(exec_trap_pkg::OFF_PCODE, 32'h1, rr);
    @(negedge aclk);
    chk(32'(parity_error_code), 32'h0, "code serviced by write");
    axw(exec_trap_pkg::OFF_MODE, 32'h0001f7ff, rr);
    chk(32'(rr), 32'(exec_trap_pkg::RESP_OKAY), "mode write response");
    axr(exec_trap_pkg::OFF_MODE, rd, rr);
    chk(rd, 32'h0001f7ff, "mode readback");
    axr(8'h20, rd, rr);
    chk({rr, rd[29:0]}, {exec_trap_pkg::RESP_SLVERR, 30'h0}, "unmapped read");
    axw(8'h20, 32'h0, rr);
    chk(32'(rr), 32'(exec_trap_pkg::RESP_SLVERR), "unmapped write");
    global_trap_enable_op <= 1'h1;
    unit_parity_errors <= 8'h10;
    stage_seven_clock <= 1'h1;
    @(posedge aclk);
    global_trap_enable_op <= 1'h0;
    stage_seven_clock <= 1'h0;
    tr(5'h1c, "machine check trap");
    @(negedge aclk);
    chk(32'({machine_check_summary, diagnostic_display}), 32'h2, "summary");
    axr(exec_trap_pkg::OFF_STATUS, rd, rr);
    chk(rd, 32'h007c1000, "status word");
    axw(exec_trap_pkg::OFF_MODE, 32'h0000f7ff, rr);
    tr(5'h00, "report off");
    unit_parity_errors <= 8'h00;
    stage_seven_clock <= 1'h1;
    @(posedge aclk);
    stage_seven_clock <= 1'h0;
    tr(5'h00, "summary cleared");
    @(negedge aclk);
    chk(32'({machine_check_summary, diagnostic_display}), 32'h1, "display later");
    @(posedge aclk);
    nonfetch_src <= 7'h48;
    transfer_trap_suppress_field <= 1'h1;
    tr(5'h1f, "mid-instruction trap");
    transfer_trap_suppress_field <= 1'h0;
    tr(5'h1b, "transfer trap");
    global_trap_disable_op <= 1'h1;
    @(posedge aclk);
    global_trap_disable_op <= 1'h0;
    tr(5'h00, "traps disabled");
    nonfetch_src <= '0;
    fetch_src <= 6'h10;
    global_trap_enable_op <= 1'h1;
    @(posedge aclk);
    global_trap_enable_op <= 1'h0;
    tr(5'h00, "fetch trap held off");
    at_boundary <= 1'h1;
    tr(5'h14, "fetch trap at boundary");
    axw(exec_trap_pkg::OFF_MODE, 32'h0000f7ef, rr);
    tr(5'h00, "source masked");
    fetch_src <= '0;
    axw(exec_trap_pkg::OFF_MODE, 32'h00000040, rr);
    while (trap_request !== 1'h1)
      @(negedge aclk);
    chk(32'(trap_code), 32'h6, "microsecond trap");
    chk(32'(cyc - rel > 40950 && cyc - rel < 41030), 32'h1, "overflow period");
    tr(5'h00, "timer trap accepted");
    conclude;
  end
endmodule
